// ---- design/asr_pkg.sv ----
/*
  Package for the asynchronous static memory host controller: pin widths,
  timing figures in ns and their cycle counts at the system clock, and the
  carrier structs.
  Assumes a 25 MHz system clock; every count is derived from CLK_NS.
*/
package asr_pkg;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 9;

  // ==========================================================
  // Timing figures, slower grade, in ns
  localparam int CLK_NS = 40;
  localparam int T_CYCLE_NS = 12;
  localparam int T_ACCESS_NS = 12;
  localparam int T_GATE_ACCESS_NS = 6;
  localparam int T_OFF_NS = 7;
  localparam int T_ADDR_END_NS = 10;
  localparam int T_WPULSE_NS = 10;
  localparam int T_DSETUP_NS = 6;
  localparam int T_WFLOAT_NS = 6;

  // Least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int RD_WAIT_CYC = cyc_up(T_ACCESS_NS);
  localparam int OFF_CYC = cyc_up(T_OFF_NS);
  localparam int WP_CYC = cyc_up(T_WPULSE_NS);
  localparam int WFLOAT_CYC = cyc_up(T_WFLOAT_NS);
  localparam int CNT_W = 4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asr_req_s;

  typedef struct packed {
    logic sel_n;
    logic sel;
    logic gate_n;
    logic wstb_n;
  } asr_ctl_s;

  localparam asr_ctl_s CTL_IDLE = '{sel_n: 1'b1, sel: 1'b0,
                                    gate_n: 1'b1, wstb_n: 1'b1};

endpackage : asr_pkg

// ---- design/asr_sync.sv ----
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes the inputs are asynchronous to clk; only stage two is read.
*/
`timescale 1ns/100ps
module asr_sync #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb
  begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end

endmodule : asr_sync

// ---- design/asr_host.sv ----
/*
  Host controller for an asynchronous 32K x 9 static memory. Takes one
  request at a time on a valid/ready port and runs a read or a write
  cycle on the memory pins, returning read data with a one-cycle pulse.
  Assumes one 25 MHz clock and that the memory sits on the board pins;
  the data pins come in raw and are synchronised before use.
*/
// Overview of operation
// RULE_01: Memory stores data during overlap of select low and strobe low.
// RULE_02: Host keeps write strobe high through every read cycle.
// RULE_03: Host drives secondary select as inverse of primary, same timing.
// RULE_04: Host holds each address stable at least the cycle time.
// RULE_05: Memory gives data within access time of address and select.
// RULE_06: Memory gives data within gate access time after gate falls.
// RULE_07: Memory holds old data briefly after address change.
// RULE_08: Memory drives no sooner than 1 ns after select falls.
// RULE_09: Memory floats within 6 or 7 ns after select rises.
// RULE_10: Memory floats within 5 or 6 ns after gate rises.
// RULE_11: Memory turn-off always faster than its turn-on.
// RULE_12: Host keeps address valid 9 or 10 ns before strobe rises.
// RULE_13: Host holds write strobe low at least 9 or 10 ns.
// RULE_14: Host sets write data 5 or 6 ns before write end, holds after.
// RULE_15: Memory floats outputs within 5 or 6 ns of strobe falling.
// RULE_16: Memory drives again no sooner than 3 ns after strobe rises.
// RULE_17: Host keeps select low 8 or 9 ns before write end.
// RULE_18: Select falling with or after strobe keeps outputs floating.
// RULE_19: Select rising with or before strobe keeps outputs floating.
// RULE_20: Host sets address no later than select falling for reads.
// RULE_21: Address-only reads assume device stays selected and gated.
// RULE_22: Memory holds 32768 words of 9 bits on shared data pins.
// RULE_23: Memory floats when deselected or gate and strobe both high.
// RULE_24: Host never drives data while memory outputs may be active.
`timescale 1ns/100ps
module asr_host (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Request port
  input wire logic REQ_VALID,
  input wire asr_pkg::asr_req_s REQ,
  output logic REQ_READY,
  // Answer port
  output logic RD_VALID,
  output logic [asr_pkg::DATA_W-1:0] RD_DATA,
  // Memory pins
  output logic [asr_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic PRIMARY_CHIP_ON_N,
  output logic AUX_CHIP_ON,
  output logic MEM_GATE_N,
  output logic MEM_WSTB_N,
  input wire logic [asr_pkg::DATA_W-1:0] MEM_DQ_I,
  output logic [asr_pkg::DATA_W-1:0] MEM_DQ_O,
  output logic MEM_DQ_OE
);

  // ==========================================================
  // State machine
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_RSEL  = 6'b000010,
    S_RWAIT = 6'b000100,
    S_WSTB  = 6'b001000,
    S_WDRV  = 6'b010000,
    S_OFF   = 6'b100000
  } asr_state_e;

  asr_state_e state_q, state_d;
  logic [asr_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [asr_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [asr_pkg::DATA_W-1:0] wdat_q, wdat_d;
  asr_pkg::asr_ctl_s ctl_q, ctl_d;
  logic oe_q, oe_d;
  logic rdy_q, rdy_d;
  logic rv_q, rv_d;
  logic [asr_pkg::DATA_W-1:0] rdat_q, rdat_d;
  logic [asr_pkg::DATA_W-1:0] dq_sync;

  // Pins cross into MCLK before the capture register reads them
  asr_sync #(.W(asr_pkg::DATA_W)) u_sync (
    .clk(MCLK),
    .rst(SYS_RST),
    .d(MEM_DQ_I),
    .q(dq_sync)
  );

  // Read wait covers access time plus the two synchroniser stages
  localparam logic [asr_pkg::CNT_W-1:0] RD_LOAD =
    asr_pkg::CNT_W'(asr_pkg::RD_WAIT_CYC + 2);
  localparam logic [asr_pkg::CNT_W-1:0] WP_LOAD =
    asr_pkg::CNT_W'(asr_pkg::WP_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] OFF_LOAD =
    asr_pkg::CNT_W'(asr_pkg::OFF_CYC);
  localparam logic [asr_pkg::CNT_W-1:0] FLT_LOAD =
    asr_pkg::CNT_W'(asr_pkg::WFLOAT_CYC);

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    ctl_d = ctl_q;
    oe_d = oe_q;
    rdy_d = 1'b0;
    rv_d = 1'b0;
    rdat_d = rdat_q;
    unique case (state_q)
      S_IDLE:
      begin
        rdy_d = 1'b1;
        if (REQ_VALID && rdy_q)
        begin
          rdy_d = 1'b0;
          // RULE_20 address set on the same edge as select
          addr_d = REQ.addr;
          wdat_d = REQ.wdata;
          // RULE_03 paired selects
          ctl_d.sel_n = 1'b0;
          ctl_d.sel = 1'b1;
          if (REQ.write)
          begin
            // RULE_18 strobe with select
            ctl_d.wstb_n = 1'b0;
            cnt_d = FLT_LOAD;
            state_d = S_WSTB;
          end
          else
          begin
            // RULE_02 strobe stays high
            ctl_d.gate_n = 1'b0;
            cnt_d = RD_LOAD;
            state_d = S_RSEL;
          end
        end
      end
      S_RSEL:
      begin
        // RULE_04 address held
        if (cnt_q == asr_pkg::CNT_W'(1))
          state_d = S_RWAIT;
        else
          cnt_d = cnt_q - asr_pkg::CNT_W'(1);
      end
      S_RWAIT:
      begin
        rdat_d = dq_sync;
        rv_d = 1'b1;
        ctl_d = asr_pkg::CTL_IDLE;
        cnt_d = OFF_LOAD;
        state_d = S_OFF;
      end
      S_WSTB:
      begin
        // RULE_24 wait for memory float
        if (cnt_q == asr_pkg::CNT_W'(1))
        begin
          oe_d = 1'b1;
          cnt_d = WP_LOAD;
          state_d = S_WDRV;
        end
        else
          cnt_d = cnt_q - asr_pkg::CNT_W'(1);
      end
      S_WDRV:
      begin
        // RULE_13 pulse width, RULE_12 RULE_14 RULE_17 setup
        if (cnt_q == asr_pkg::CNT_W'(1))
        begin
          // RULE_19 select and strobe rise together; data held one more
          ctl_d = asr_pkg::CTL_IDLE;
          cnt_d = OFF_LOAD;
          state_d = S_OFF;
        end
        else
          cnt_d = cnt_q - asr_pkg::CNT_W'(1);
      end
      S_OFF:
      begin
        oe_d = 1'b0;
        // RULE_24 turn-off gap before next cycle
        if (cnt_q == asr_pkg::CNT_W'(1))
        begin
          state_d = S_IDLE;
          rdy_d = 1'b1;
        end
        else
          cnt_d = cnt_q - asr_pkg::CNT_W'(1);
      end
      default:
      begin
        state_d = S_IDLE;
        ctl_d = asr_pkg::CTL_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      addr_q <= '0;
      wdat_q <= '0;
      ctl_q <= asr_pkg::CTL_IDLE;
      oe_q <= 1'b0;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
      rdat_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      ctl_q <= ctl_d;
      oe_q <= oe_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  always_comb
  begin
    REQ_READY = rdy_q;
    RD_VALID = rv_q;
    RD_DATA = rdat_q;
    MEM_ADDR = addr_q;
    PRIMARY_CHIP_ON_N = ctl_q.sel_n;
    AUX_CHIP_ON = ctl_q.sel;
    MEM_GATE_N = ctl_q.gate_n;
    MEM_WSTB_N = ctl_q.wstb_n;
    MEM_DQ_O = wdat_q;
    MEM_DQ_OE = oe_q;
  end

endmodule : asr_host

// ---- testbench/asr_chk.sv ----
/*
  Checker on the host's memory pins and request port.
  Assumes it is bound to asr_host by the bench top file.
*/
`timescale 1ns/100ps
module asr_chk (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Request and answer
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire asr_pkg::asr_req_s REQ,
  input wire logic RD_VALID,
  // Memory pins
  input wire logic [asr_pkg::ADDR_W-1:0] MEM_ADDR,
  input wire logic PRIMARY_CHIP_ON_N,
  input wire logic AUX_CHIP_ON,
  input wire logic MEM_GATE_N,
  input wire logic MEM_WSTB_N,
  input wire logic [asr_pkg::DATA_W-1:0] MEM_DQ_O,
  input wire logic MEM_DQ_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================
  // Cycle shapes
  sequence s_wlow;
    !MEM_WSTB_N ##1 !MEM_WSTB_N ##1 MEM_WSTB_N;
  endsequence
  sequence s_wsel;
    $fell(PRIMARY_CHIP_ON_N) ##1 !PRIMARY_CHIP_ON_N ##1 PRIMARY_CHIP_ON_N;
  endsequence
  sequence s_rd_take;
    REQ_VALID && REQ_READY && !REQ.write;
  endsequence
  property p_sel_pair;
    AUX_CHIP_ON == !PRIMARY_CHIP_ON_N;
  endproperty
  property p_wr_width;
    $fell(MEM_WSTB_N) |-> s_wlow;
  endproperty
  property p_rd_strobe;
    !MEM_GATE_N |-> MEM_WSTB_N;
  endproperty
  property p_no_fight;
    $fell(MEM_WSTB_N) |-> !MEM_DQ_OE ##1 (MEM_DQ_OE && MEM_GATE_N);
  endproperty
  property p_wr_addr;
    $fell(MEM_WSTB_N) |=> $stable(MEM_ADDR)[*2];
  endproperty
  property p_wr_data;
    $fell(MEM_WSTB_N) |=> ##1 (MEM_DQ_OE && $stable(MEM_DQ_O));
  endproperty
  property p_wr_sel;
    $fell(MEM_WSTB_N) |-> s_wsel;
  endproperty
  property p_rd_addr;
    s_rd_take |=> (!PRIMARY_CHIP_ON_N && !MEM_GATE_N &&
      MEM_ADDR == $past(REQ.addr)) ##4 RD_VALID;
  endproperty
  a_sel_pair: assert property (p_sel_pair)
    else $error("secondary select not inverse of primary");
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe width wrong");
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("strobe low while gate low");
  a_no_fight: assert property (p_no_fight)
    else $error("data driven before memory floats");
  a_wr_addr: assert property (p_wr_addr)
    else $error("address moved during write");
  a_wr_data: assert property (p_wr_data)
    else $error("write data not held to write end");
  a_wr_sel: assert property (p_wr_sel)
    else $error("select not framing write");
  a_rd_addr: assert property (p_rd_addr)
    else $error("read cycle shape wrong");
endmodule : asr_chk

// ---- testbench/asr_mem_model.sv ----
/*
  Behavioural 32K x 9 asynchronous static memory.
  Assumes it forms the shared data wire from both parties' enables.
*/
`timescale 1ns/100ps
module asr_mem_model (
  // Control pins
  input wire logic [asr_pkg::ADDR_W-1:0] addr,
  input wire logic sel_n,
  input wire logic sel,
  input wire logic gate_n,
  input wire logic wstb_n,
  // Data wire
  input wire logic [asr_pkg::DATA_W-1:0] host_dq,
  input wire logic host_oe,
  output logic [asr_pkg::DATA_W-1:0] dq
);
  // ==========================================================
  // Array and output
  // word array
  logic [asr_pkg::DATA_W-1:0] mem [0:32767];
  logic [asr_pkg::DATA_W-1:0] rd;
  logic [asr_pkg::DATA_W-1:0] last = '0;
  logic on;
  always @* if (!sel_n && sel && !wstb_n) mem[addr] = dq;
  assign #4 rd = mem[addr];
  assign #(3, 0) on = !sel_n && sel && !gate_n && wstb_n;
  // released wire shows inverse, no pull
  always @* if (on) last = rd;
  assign dq = host_oe ? host_dq : (on ? rd : ~last);
endmodule : asr_mem_model

// ---- testbench/tb_top.sv ----
/*
  Bench for the static memory host: random writes and read-backs.
  Assumes asr_host, asr_chk and the memory model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  asr_pkg::asr_req_s req = '0;
  logic ready, rd_valid, sel_n, aux, gate_n, wstb_n, oe;
  logic [8:0] rd_data, dq_o, dq;
  logic [14:0] addr;
  logic [31:0] rng = 32'h0000EB1B;
  logic [8:0] shadow [0:32767];
  int errors = 0;
  int checked = 0;
  always #20 mclk = ~mclk;
  asr_host DUT (.MCLK(mclk), .SYS_RST(sys_rst), .REQ_VALID(req_valid),
    .REQ(req), .REQ_READY(ready), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .MEM_ADDR(addr), .PRIMARY_CHIP_ON_N(sel_n), .AUX_CHIP_ON(aux),
    .MEM_GATE_N(gate_n), .MEM_WSTB_N(wstb_n), .MEM_DQ_I(dq),
    .MEM_DQ_O(dq_o), .MEM_DQ_OE(oe));
  asr_mem_model u_mem (.addr(addr), .sel_n(sel_n), .sel(aux),
    .gate_n(gate_n), .wstb_n(wstb_n), .host_dq(dq_o), .host_oe(oe),
    .dq(dq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  // ==========================================================
  // One request, read answer timed from the taking edge
  task automatic run(input logic w, input logic [14:0] a,
    input logic [8:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    // A ready that never returns counts against the run
    check({15'h0000, ready}, 16'h0001);
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    rng = xs(rng);
    // Idle request bits must be ignored
    req = asr_pkg::asr_req_s'(rng[24:0]);
    if (w)
      shadow[a] = d;
    else
    begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 9)
      begin
        @(posedge mclk);
        #1;
        n++;
      end
      check(n[15:0], 16'h0004);
      check({7'h00, rd_data}, {7'h00, shadow[a]});
    end
  endtask : run
  initial
  begin
    repeat (16) @(posedge mclk);
    check({sel_n, aux, gate_n, wstb_n, oe, ready}, 16'h002C);
    #1 sys_rst = 1'b0;
    run(1'b1, 15'h7FFF, 9'h1FF);
    run(1'b1, 15'h0000, 9'h000);
    run(1'b0, 15'h7FFF, 9'h000);
    run(1'b0, 15'h0000, 9'h000);
    $display("corner test done");
    for (int i = 0; i < 100; i++)
    begin
      logic [14:0] ra;
      rng = xs(rng);
      // Each run moves rng on, so the address is kept for the read-back
      ra = rng[14:0];
      run(1'b1, ra, rng[31:23]);
      run(1'b0, ra, 9'h000);
      run(1'b0, 15'h7FFF, 9'h000);
    end
    $display("random test done");
    complete_run();
  end
  initial
  begin
    #200000;
    errors++;
    complete_run();
  end
endmodule : tb_top
bind asr_host asr_chk u_chk (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ(REQ),
  .RD_VALID(RD_VALID), .MEM_ADDR(MEM_ADDR),
  .PRIMARY_CHIP_ON_N(PRIMARY_CHIP_ON_N), .AUX_CHIP_ON(AUX_CHIP_ON),
  .MEM_GATE_N(MEM_GATE_N), .MEM_WSTB_N(MEM_WSTB_N),
  .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE));
